// >>> verilog/seac_pkg.sv
// Constants and types for the serial configuration memory access controller.
// Assumes a single primary clock; all timing is counted in its cycles.
package seac_pkg;

   // Register offsets in configuration space
   localparam logic [11:0] SEAC_CTRL_OFS      = 12'h87C;
   localparam logic [11:0] SEAC_ADDR_DATA_OFS = 12'h880;

   // Control register field positions
   localparam int SEAC_START_BIT    = 0;
   localparam int SEAC_AUTO_OK_BIT  = 4;
   localparam int SEAC_AUTO_DIS_BIT = 5;
   localparam int SEAC_RATE_LSB     = 6;
   localparam int SEAC_STATUS_LSB   = 8;
   localparam int SEAC_CMD_LSB      = 16;
   localparam int SEAC_SIZE_BIT     = 31;

   // Reset values
   localparam logic [1:0]  SEAC_RATE_RESET   = 2'h1;
   localparam logic [7:0]  SEAC_STATUS_RESET = 8'h00;
   localparam logic [7:0]  SEAC_CMD_RESET    = 8'h00;
   localparam logic [15:0] SEAC_WORD_RESET   = 16'h0000;

   // Memory command codes
   localparam logic [7:0] SEAC_CMD_WRSR  = 8'h01;
   localparam logic [7:0] SEAC_CMD_WRITE = 8'h02;
   localparam logic [7:0] SEAC_CMD_READ  = 8'h03;
   localparam logic [7:0] SEAC_CMD_WRDI  = 8'h04;
   localparam logic [7:0] SEAC_CMD_RDSR  = 8'h05;
   localparam logic [7:0] SEAC_CMD_WREN  = 8'h06;
   localparam logic [7:0] SEAC_CMD_ERASE = 8'hC7;

   // Serial clock: primary clock divided by four, half high and half low
   localparam logic [1:0] SEAC_DIV_RISE = 2'h1;
   localparam logic [1:0] SEAC_DIV_LAST = 2'h3;

   // Frame lengths in bits
   localparam logic [5:0] SEAC_FRAME_OP   = 6'h08;
   localparam logic [5:0] SEAC_FRAME_STS  = 6'h10;
   localparam logic [5:0] SEAC_FRAME_NARW = 6'h28;
   localparam logic [5:0] SEAC_FRAME_WIDE = 6'h30;

   // Autoload reads this word and expects this marker (value is arbitrary)
   localparam logic [15:0] SEAC_AUTO_ADDR = 16'h0000;
   localparam logic [15:0] SEAC_AUTO_SIG  = 16'h5A3C;

   typedef enum logic [1:0] {
      SEAC_BOOT,
      SEAC_AUTO,
      SEAC_IDLE,
      SEAC_RUN
   } seac_state_t;

endpackage

// >>> verilog/seac_spi_engine.sv
// Serial shift engine: sends a left-aligned frame MSB first and captures input.
// Assumes the caller holds start for one cycle only while the engine is idle.
`timescale 1ns/1ps
module seac_spi_engine
   import seac_pkg::*;
(
   input  wire logic        ref_clk_in,  // Primary clock
   input  wire logic        resetn_in,   // Async reset, active low
   input  wire logic        start_in,    // Launch a frame
   input  wire logic [5:0]  nbits_in,    // Frame length in bits
   input  wire logic [47:0] tx_in,       // Frame, MSB first
   output logic             busy_out,    // Frame in progress
   output logic             done_out,    // Frame finished pulse
   output logic [15:0]      rx_out,      // Last 16 bits captured
   output logic             sck_out,     // Serial clock
   output logic             cs_n_out,    // Chip select, active low
   output logic             mosi_out,    // Serial data out
   input  wire logic        miso_in      // Serial data in
);

   logic        active, next_active;
   logic [1:0]  div, next_div;
   logic [5:0]  cnt, next_cnt;
   logic [47:0] sh, next_sh;
   logic [15:0] rx, next_rx;
   logic        sck, next_sck;
   logic        done, next_done;
   logic        cs_n, next_cs_n;

   always_comb begin
      next_active = active;
      next_div    = div;
      next_cnt    = cnt;
      next_sh     = sh;
      next_rx     = rx;
      next_sck    = sck;
      next_done   = 1'b0;
      if (!active) begin
         if (start_in) begin
            next_active = 1'b1;
            next_sh     = tx_in;
            next_cnt    = nbits_in;
            next_div    = 2'h0;
         end
      end else begin
         next_div = div + 2'h1;
         if (div == SEAC_DIV_RISE) begin
            next_sck = 1'b1;
            next_rx  = {rx[14:0], miso_in};
         end
         if (div == SEAC_DIV_LAST) begin
            next_sck = 1'b0;
            next_sh  = {sh[46:0], 1'b0};
            next_cnt = cnt - 6'h01;
            if (cnt == 6'h01) begin
               next_active = 1'b0;
               next_done   = 1'b1;
            end
         end
      end
      next_cs_n = !next_active;
   end

   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         active <= 1'b0;
         div    <= 2'h0;
         cnt    <= 6'h00;
         sh     <= 48'h0;
         rx     <= 16'h0000;
         sck    <= 1'b0;
         done   <= 1'b0;
         cs_n   <= 1'b1;
      end else begin
         active <= next_active;
         div    <= next_div;
         cnt    <= next_cnt;
         sh     <= next_sh;
         rx     <= next_rx;
         sck    <= next_sck;
         done   <= next_done;
         cs_n   <= next_cs_n;
      end
   end

   assign busy_out = active;
   assign done_out = done;
   assign rx_out   = rx;
   assign sck_out  = sck;
   assign cs_n_out = cs_n;
   assign mosi_out = sh[47];

   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!resetn_in);

   a_sck_div_four: assert property ($rose(sck) |-> sck ##1 sck ##1 !sck ##1 !sck)
      else $error("serial clock not primary clock over four");

endmodule

// >>> verilog/seac_ctrl.sv
// Serial configuration memory access controller, upstream port registers.
// Assumes a simple config-space port: one-cycle write and read strobes.
// How it works
// - Writing 1 to control bit 0 starts the memory cycle chosen by the command field.
// - Control bit 4 reads 1 only after a successful autoload, else 0.
// - Autoload is skipped when control bit 5 is 1 and done when it is 0.
// - The serial clock is the primary clock divided by four, rate field 7:6 resets to 01b.
// - Control bits 15:8 show the memory status byte, reset 00h.
// - Command 01h writes and 05h reads the memory status register.
// - Command 06h enables writes and 04h disables writes in the memory.
// - Command C7h erases the whole memory.
// - Command 02h writes a data word and 03h reads one.
// - Control bit 31 selects 24-bit addressing for memories above 64K.
// - Address/data bits 15:0 hold the targeted location, reset zero.
// - Address/data bits 31:16 hold the word sent on writes and returned on reads.
// - The two registers sit at 87Ch and 880h of upstream configuration space.
`timescale 1ns/1ps
module seac_ctrl
   import seac_pkg::*;
(
   input  wire logic        ref_clk_in,    // Primary clock
   input  wire logic        resetn_in,     // Async reset, active low
   input  wire logic        cfg_wr_in,     // Config write strobe
   input  wire logic        cfg_rd_in,     // Config read strobe
   input  wire logic [11:0] cfg_addr_in,   // Config byte offset
   input  wire logic [31:0] cfg_wdata_in,  // Config write data
   output logic [31:0]      cfg_rdata_out, // Config read data
   output logic             cfg_rvalid_out,// Read data valid pulse
   output logic             mem_sck_out,   // Memory serial clock
   output logic             mem_cs_n_out,  // Memory select, active low
   output logic             mem_mosi_out,  // Data to memory
   input  wire logic        mem_miso_in    // Data from memory
);

   seac_state_t st, next_st;
   logic        start, next_start;
   logic        auto_ok, next_auto_ok;
   logic        auto_dis, next_auto_dis;
   logic [1:0]  rate, next_rate;
   logic [7:0]  status, next_status;
   logic [7:0]  cmd, next_cmd;
   logic        size, next_size;
   logic [15:0] maddr, next_maddr;
   logic [15:0] mdata, next_mdata;
   logic [31:0] rdata, next_rdata;
   logic        rvalid, next_rvalid;
   logic        eng_start, next_eng_start;
   logic [5:0]  eng_nbits, next_eng_nbits;
   logic [47:0] eng_tx, next_eng_tx;
   logic        eng_busy;
   logic        eng_done;
   logic [15:0] eng_rx;
   logic [31:0] ctrl_word;

   assign ctrl_word = {size, 7'h00, cmd, status, rate, auto_dis, auto_ok, 3'h0, start};

   always_comb begin
      logic        fr_ok;
      logic [5:0]  fr_bits;
      logic [47:0] fr_tx;
      fr_ok   = 1'b1;
      fr_bits = SEAC_FRAME_OP;
      fr_tx   = 48'h0;
      unique case (cmd)
         SEAC_CMD_WREN, SEAC_CMD_WRDI: begin
            fr_tx = {cmd, 40'h0};
         end
         SEAC_CMD_ERASE: begin
            fr_tx = {cmd, 40'h0};
         end
         SEAC_CMD_WRSR: begin
            fr_bits = SEAC_FRAME_STS;
            fr_tx   = {cmd, mdata[7:0], 32'h0};
         end
         SEAC_CMD_RDSR: begin
            fr_bits = SEAC_FRAME_STS;
            fr_tx   = {cmd, 40'h0};
         end
         SEAC_CMD_WRITE, SEAC_CMD_READ: begin
            if (size) begin
               fr_bits = SEAC_FRAME_WIDE;
               fr_tx   = {cmd, 8'h00, maddr, mdata};
            end else begin
               fr_bits = SEAC_FRAME_NARW;
               fr_tx   = {cmd, maddr, mdata, 8'h00};
            end
         end
         default: begin
            fr_ok = 1'b0;
         end
      endcase

      next_st        = st;
      next_start     = start;
      next_auto_ok   = auto_ok;
      next_auto_dis  = auto_dis;
      next_rate      = rate;
      next_status    = status;
      next_cmd       = cmd;
      next_size      = size;
      next_maddr     = maddr;
      next_mdata     = mdata;
      next_eng_start = 1'b0;
      next_eng_nbits = eng_nbits;
      next_eng_tx    = eng_tx;
      next_rvalid    = cfg_rd_in;
      next_rdata     = 32'h0;

      if (cfg_rd_in) begin
         if (cfg_addr_in == SEAC_CTRL_OFS) begin
            next_rdata = ctrl_word;
         end else if (cfg_addr_in == SEAC_ADDR_DATA_OFS) begin
            next_rdata = {mdata, maddr};
         end
      end

      if (cfg_wr_in && cfg_addr_in == SEAC_CTRL_OFS) begin
         if (!start) begin
            next_start = cfg_wdata_in[SEAC_START_BIT];
         end
         next_auto_dis = cfg_wdata_in[SEAC_AUTO_DIS_BIT];
         next_rate     = cfg_wdata_in[SEAC_RATE_LSB +: 2];
         next_cmd      = cfg_wdata_in[SEAC_CMD_LSB +: 8];
         next_size     = cfg_wdata_in[SEAC_SIZE_BIT];
      end
      if (cfg_wr_in && cfg_addr_in == SEAC_ADDR_DATA_OFS) begin
         next_maddr = cfg_wdata_in[15:0];
         next_mdata = cfg_wdata_in[31:16];
      end

      unique case (st)
         SEAC_BOOT: begin
            // A control write on the first edge after reset can still skip the load
            if (next_auto_dis) begin
               next_auto_ok = 1'b0;
               next_st      = SEAC_IDLE;
            end else begin
               next_eng_start = 1'b1;
               next_eng_nbits = SEAC_FRAME_NARW;
               next_eng_tx    = {SEAC_CMD_READ, SEAC_AUTO_ADDR, 24'h0};
               next_st        = SEAC_AUTO;
            end
         end
         SEAC_AUTO: begin
            if (eng_done) begin
               next_auto_ok = (eng_rx == SEAC_AUTO_SIG);
               next_st      = SEAC_IDLE;
            end
         end
         SEAC_IDLE: begin
            if (start) begin
               if (fr_ok) begin
                  next_eng_start = 1'b1;
                  next_eng_nbits = fr_bits;
                  next_eng_tx    = fr_tx;
                  next_st        = SEAC_RUN;
               end else begin
                  next_start = 1'b0;
               end
            end
         end
         SEAC_RUN: begin
            if (eng_done) begin
               if (cmd == SEAC_CMD_RDSR) begin
                  next_status = eng_rx[7:0];
               end
               if (cmd == SEAC_CMD_READ) begin
                  next_mdata = eng_rx;
               end
               next_start = 1'b0;
               next_st    = SEAC_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         st        <= SEAC_BOOT;
         start     <= 1'b0;
         auto_ok   <= 1'b0;
         auto_dis  <= 1'b0;
         rate      <= SEAC_RATE_RESET;
         status    <= SEAC_STATUS_RESET;
         cmd       <= SEAC_CMD_RESET;
         size      <= 1'b0;
         maddr     <= SEAC_WORD_RESET;
         mdata     <= SEAC_WORD_RESET;
         rdata     <= 32'h0;
         rvalid    <= 1'b0;
         eng_start <= 1'b0;
         eng_nbits <= 6'h00;
         eng_tx    <= 48'h0;
      end else begin
         st        <= next_st;
         start     <= next_start;
         auto_ok   <= next_auto_ok;
         auto_dis  <= next_auto_dis;
         rate      <= next_rate;
         status    <= next_status;
         cmd       <= next_cmd;
         size      <= next_size;
         maddr     <= next_maddr;
         mdata     <= next_mdata;
         rdata     <= next_rdata;
         rvalid    <= next_rvalid;
         eng_start <= next_eng_start;
         eng_nbits <= next_eng_nbits;
         eng_tx    <= next_eng_tx;
      end
   end

   assign cfg_rdata_out  = rdata;
   assign cfg_rvalid_out = rvalid;

   seac_spi_engine u_engine (
      .ref_clk_in (ref_clk_in),
      .resetn_in  (resetn_in),
      .start_in   (eng_start),
      .nbits_in   (eng_nbits),
      .tx_in      (eng_tx),
      .busy_out   (eng_busy),
      .done_out   (eng_done),
      .rx_out     (eng_rx),
      .sck_out    (mem_sck_out),
      .cs_n_out   (mem_cs_n_out),
      .mosi_out   (mem_mosi_out),
      .miso_in    (mem_miso_in)
   );

   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!resetn_in);

   sequence s_launch(logic [7:0] c);
      st == SEAC_IDLE && start && cmd == c;
   endsequence

   a_start_launch: assert property (st == SEAC_IDLE && start && next_st == SEAC_RUN |=>
      eng_start ##1 eng_busy) else $error("start did not launch a frame");
   a_autoload_flag: assert property ($rose(auto_ok) |->
      $past(st) == SEAC_AUTO && $past(eng_rx) == SEAC_AUTO_SIG) else $error("bad autoload flag");
   a_autoload_skip: assert property (st == SEAC_BOOT && next_auto_dis |=>
      st == SEAC_IDLE && !eng_start && !auto_ok) else $error("autoload not skipped");
   a_status_take: assert property (st == SEAC_RUN && eng_done && cmd == SEAC_CMD_RDSR
      |=> status == $past(eng_rx[7:0])) else $error("status byte not captured");
   a_status_frame: assert property (s_launch(SEAC_CMD_WRSR) |=>
      eng_nbits == SEAC_FRAME_STS && eng_tx[47:40] == SEAC_CMD_WRSR)
      else $error("status write frame wrong");
   a_wren_frame: assert property (s_launch(SEAC_CMD_WREN) |=>
      eng_nbits == SEAC_FRAME_OP && eng_tx[47:40] == SEAC_CMD_WREN)
      else $error("write enable frame wrong");
   a_erase_frame: assert property (s_launch(SEAC_CMD_ERASE) |=>
      eng_nbits == SEAC_FRAME_OP && eng_tx[47:40] == SEAC_CMD_ERASE)
      else $error("erase frame wrong");
   a_read_size: assert property (s_launch(SEAC_CMD_READ) ##0 size |=>
      eng_nbits == SEAC_FRAME_WIDE && eng_tx[39:32] == 8'h00)
      else $error("wide read frame wrong");
   a_read_data: assert property (st == SEAC_RUN && eng_done && cmd == SEAC_CMD_READ
      |=> mdata == $past(eng_rx)) else $error("read data not returned");
   a_start_clear: assert property (st == SEAC_RUN && eng_done |=> !start ##1 !start)
      else $error("start bit did not clear");

endmodule

// >>> dv/seac_mem_model.sv
// Behavioural serial configuration memory facing the access controller.
// Assumes mode 0 framing, select active low, and a wide-address flag from the bench.
`timescale 1ns/1ps
module seac_mem_model (
   input  wire logic ref_clk_in, // Primary clock, paces idle line noise
   input  wire logic wide_in,    // Wide addressing in use
   input  wire logic sck_in,     // Serial clock
   input  wire logic cs_n_in,    // Select, active low
   input  wire logic mosi_in,    // Data from controller
   output logic      miso_out    // Data to controller
);
   logic [15:0] mem [0:65535];
   logic [47:0] frame = 48'h0;
   logic [7:0]  op = 8'h00;
   logic [5:0]  nbits = 6'h00;
   logic [15:0] sh = 16'hA5A5;
   logic [7:2]  sts = 6'h00;
   logic        wel = 1'b0;
   int          frames = 0;
   initial begin
      miso_out = 1'b0;
      for (int i = 0; i < 65536; i++) begin
         mem[i] = 16'hFFFF;
      end
   end
   // Released line shows a changing pattern, never the last bit
   always @(posedge ref_clk_in) if (cs_n_in) miso_out <= ~miso_out;
   always @(negedge cs_n_in) begin
      nbits = 6'h00;
      frame = 48'h0;
   end
   always @(posedge sck_in) if (!cs_n_in) begin
      frame = {frame[46:0], mosi_in};
      nbits = nbits + 6'h01;
      if (nbits == 6'h08) op = frame[7:0];
      if (nbits == 6'h08 && frame[7:0] == 8'h05) sh = {sts, wel, 1'b0, 8'h00};
      if (op == 8'h03 && nbits == (wide_in ? 6'h20 : 6'h18)) sh = mem[frame[15:0]];
   end
   always @(negedge sck_in) if (!cs_n_in) begin
      miso_out = sh[15];
      sh = {sh[14:0], 1'b0};
   end
   always @(posedge cs_n_in) begin
      frames++;
      case (op)
         8'h06: wel = 1'b1;
         8'h04: wel = 1'b0;
         8'h01: sts = frame[7:2];
         8'hC7: if (wel) begin
            for (int i = 0; i < 65536; i++) mem[i] = 16'hFFFF;
            wel = 1'b0;
         end
         8'h02: if (wel) begin
            mem[frame[31:16]] = frame[15:0];
            wel = 1'b0;
         end
         default: ;
      endcase
   end
endmodule

// >>> dv/seac_ctrl_tb_top.sv
// Self-checking bench for the serial memory access controller.
// Assumes the memory model above on the serial side and strobes driven at falling edges.
`timescale 1ns/1ps
module seac_ctrl_tb_top
   import seac_pkg::*;
;
   logic        ref_clk_in;
   logic        resetn_in;
   logic        cfg_wr_in;
   logic        cfg_rd_in;
   logic [11:0] cfg_addr_in;
   logic [31:0] cfg_wdata_in;
   logic [31:0] cfg_rdata_out;
   logic        cfg_rvalid_out;
   logic        mem_sck_out;
   logic        mem_cs_n_out;
   logic        mem_mosi_out;
   logic        mem_miso_in;
   logic        wide;
   int          bad_count = 0;
   int          n_checks = 0;
   int          cycles = 0;

   seac_ctrl u_dut (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .cfg_wr_in(cfg_wr_in),
      .cfg_rd_in(cfg_rd_in), .cfg_addr_in(cfg_addr_in), .cfg_wdata_in(cfg_wdata_in),
      .cfg_rdata_out(cfg_rdata_out), .cfg_rvalid_out(cfg_rvalid_out),
      .mem_sck_out(mem_sck_out), .mem_cs_n_out(mem_cs_n_out), .mem_mosi_out(mem_mosi_out),
      .mem_miso_in(mem_miso_in));
   seac_mem_model u_mem (.ref_clk_in(ref_clk_in), .wide_in(wide), .sck_in(mem_sck_out),
      .cs_n_in(mem_cs_n_out), .mosi_in(mem_mosi_out), .miso_out(mem_miso_in));

   initial begin
      ref_clk_in = 1'b0;
      forever #50 ref_clk_in = ~ref_clk_in;
   end

   task automatic end_sim();
      if (bad_count == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   // Whole run needs some 2100 cycles
   always @(posedge ref_clk_in) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         end_sim();
      end
   end

   task automatic check32(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic cfg_write(input logic [11:0] a, input logic [31:0] d);
      @(negedge ref_clk_in);
      cfg_addr_in = a;
      cfg_wdata_in = d;
      cfg_wr_in = 1'b1;
      @(negedge ref_clk_in);
      cfg_wr_in = 1'b0;
   endtask

   task automatic cfg_read(input logic [11:0] a, output logic [31:0] d);
      @(negedge ref_clk_in);
      cfg_addr_in = a;
      cfg_rd_in = 1'b1;
      @(negedge ref_clk_in);
      check32("read valid", 32'h1, {31'h0, cfg_rvalid_out});
      d = cfg_rdata_out;
      cfg_rd_in = 1'b0;
   endtask

   task automatic check_frame(input logic [5:0] n, input logic [47:0] f);
      check32("frame bits", {26'h0, n}, {26'h0, u_mem.nbits});
      check32("frame high", {16'h0, f[47:32]}, {16'h0, u_mem.frame[47:32]});
      check32("frame low", f[31:0], u_mem.frame[31:0]);
   endtask

   // Address/data is set before start, command goes in the same write as start, and nothing is written until start reads back 0
   task automatic run_cmd(input logic [7:0] cmd, input logic sz, input logic [31:0] ad,
                          output logic [31:0] ctl);
      int n;
      cfg_write(SEAC_ADDR_DATA_OFS, ad);
      cfg_write(SEAC_CTRL_OFS, {sz, 7'h00, cmd, 8'h00, 8'h41});
      n = 0;
      ctl = 32'h1;
      while (ctl[0] === 1'b1 && n < 200) begin
         cfg_read(SEAC_CTRL_OFS, ctl);
         n++;
      end
      check32("start bit", 32'h0, {31'h0, ctl[0]});
   endtask

   // With skip set, a write of the disable bit lands on the first edge after release
   task automatic do_reset(input logic [15:0] w0, input logic skip);
      resetn_in = 1'b0;
      repeat (6) @(negedge ref_clk_in);
      u_mem.mem[0] = w0;
      cfg_addr_in = SEAC_CTRL_OFS;
      cfg_wdata_in = {24'h0, 2'h1, skip, 5'h00};
      cfg_wr_in = skip;
      resetn_in = 1'b1;
      @(negedge ref_clk_in);
      cfg_wr_in = 1'b0;
   endtask

   task automatic t_skip();
      logic [31:0] r;
      int          f0;
      f0 = u_mem.frames;
      repeat (200) @(negedge ref_clk_in);
      check32("skip frames", f0, u_mem.frames);
      cfg_read(SEAC_CTRL_OFS, r);
      check32("skip status", 32'h0000_0060, r);
   endtask

   task automatic t_reset(input logic [31:0] after);
      logic [31:0] r;
      cfg_read(SEAC_CTRL_OFS, r);
      check32("control reset", 32'h0000_0040, r);
      cfg_read(SEAC_ADDR_DATA_OFS, r);
      check32("addr data reset", 32'h0, r);
      repeat (200) @(negedge ref_clk_in);
      check_frame(6'h28, {8'h00, 8'h03, SEAC_AUTO_ADDR, 16'h0000});
      cfg_read(SEAC_CTRL_OFS, r);
      check32("autoload status", after, r);
   endtask

   task automatic t_status();
      logic [31:0] ctl;
      run_cmd(SEAC_CMD_WREN, 1'b0, 32'h0, ctl);
      check_frame(6'h08, 48'h06);
      run_cmd(SEAC_CMD_RDSR, 1'b0, 32'h0, ctl);
      check32("status wel", 32'h02, {24'h0, ctl[15:8]});
      run_cmd(SEAC_CMD_WRDI, 1'b0, 32'h0, ctl);
      check_frame(6'h08, 48'h04);
      run_cmd(SEAC_CMD_WRSR, 1'b0, 32'h00FC_0000, ctl);
      check_frame(6'h10, 48'h01FC);
      run_cmd(SEAC_CMD_RDSR, 1'b0, 32'h0, ctl);
      check32("status byte", 32'hFC, {24'h0, ctl[15:8]});
   endtask

   task automatic t_access();
      logic [31:0] r;
      cfg_write(SEAC_CTRL_OFS, 32'hFFFF_FFFE);
      cfg_read(SEAC_CTRL_OFS, r);
      check32("control access", 32'h80FF_FCF0, r);
      cfg_write(SEAC_CTRL_OFS, 32'h0000_0040);
      cfg_read(12'h884, r);
      check32("unmapped read", 32'h0, r);
   endtask

   task automatic t_data();
      logic [31:0] ctl;
      logic [15:0] a;
      logic [15:0] d;
      for (int s = 0; s < 2; s++) begin
         a = s ? 16'h00AB : 16'h1234;
         d = s ? 16'h1357 : 16'hBEEF;
         wide = s[0];
         run_cmd(SEAC_CMD_WREN, s[0], 32'h0, ctl);
         run_cmd(SEAC_CMD_WRITE, s[0], {d, a}, ctl);
         check_frame(s ? 6'h30 : 6'h28, s ? {8'h02, 8'h00, a, d} : {8'h00, 8'h02, a, d});
         run_cmd(SEAC_CMD_READ, s[0], {16'h0000, a}, ctl);
         cfg_read(SEAC_ADDR_DATA_OFS, ctl);
         check32("read word", {d, a}, ctl);
      end
      wide = 1'b0;
   endtask

   task automatic t_erase();
      logic [31:0] ctl;
      int          f0;
      run_cmd(SEAC_CMD_WREN, 1'b0, 32'h0, ctl);
      run_cmd(SEAC_CMD_ERASE, 1'b0, 32'h0, ctl);
      check_frame(6'h08, 48'hC7);
      run_cmd(SEAC_CMD_READ, 1'b0, 32'h0000_1234, ctl);
      cfg_read(SEAC_ADDR_DATA_OFS, ctl);
      check32("erased word", 32'hFFFF_1234, ctl);
      f0 = u_mem.frames;
      run_cmd(8'h55, 1'b0, 32'h0, ctl);
      check32("no frame", f0, u_mem.frames);
   endtask

   initial begin
      cfg_wr_in = 1'b0;
      cfg_rd_in = 1'b0;
      cfg_addr_in = 12'h000;
      cfg_wdata_in = 32'h0;
      wide = 1'b0;
      do_reset(SEAC_AUTO_SIG, 1'b0);
      t_reset(32'h0000_0050);
      t_status();
      t_access();
      t_data();
      t_erase();
      do_reset(16'h1234, 1'b0);
      t_reset(32'h0000_0040);
      do_reset(SEAC_AUTO_SIG, 1'b1);
      t_skip();
      end_sim();
   end
endmodule
